// *** design/mmac_pkg.sv ***
// Shared constants, codes and decode functions of the memory map access control hub.
package mmac_pkg;
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int RADDR_W = 16;
   localparam int CODE_W = 4;
   localparam int NINIT = 3;
   localparam int NRES = 3;
   localparam int CPU_STATE_W = 3;
   localparam int IRQ_W = 2;

   typedef logic [CODE_W-1:0] mmac_code_t;
   typedef logic [1:0] mmac_res_t;

   // Initiator slots, lowest index wins arbitration.
   localparam int IX_BDC = 0;
   localparam int IX_CPU = 1;
   localparam int IX_ADC = 2;

   localparam mmac_res_t RES_PER = 2'h0;
   localparam mmac_res_t RES_RAM = 2'h1;
   localparam mmac_res_t RES_NVM = 2'h2;

   localparam mmac_code_t ITR_NONE = 4'h0;
   localparam mmac_code_t ITR_CPU = 4'h1;
   localparam mmac_code_t ITR_ADC = 4'h3;

   localparam mmac_code_t TGT_NONE = 4'h0;
   localparam mmac_code_t TGT_REG = 4'h1;
   localparam mmac_code_t TGT_RAM = 4'h2;
   localparam mmac_code_t TGT_EEP = 4'h3;
   localparam mmac_code_t TGT_PFL = 4'h4;
   localparam mmac_code_t TGT_IFR = 4'h5;

   localparam mmac_code_t ACC_NONE = 4'h0;
   localparam mmac_code_t ACC_OPC = 4'h1;
   localparam mmac_code_t ACC_VEC = 4'h2;
   localparam mmac_code_t ACC_LOAD = 4'h3;
   localparam mmac_code_t ACC_STORE = 4'h4;

   localparam mmac_code_t ERR_NONE = 4'h0;
   localparam mmac_code_t ERR_ILL = 4'h1;
   localparam mmac_code_t ERR_ECC = 4'h2;

   // Region bounds inside the 16 MByte space; gaps are unmapped.
   localparam logic [ADDR_W-1:0] REG_LO = 24'h000000;
   localparam logic [ADDR_W-1:0] REG_HI = 24'h000fff;
   localparam logic [ADDR_W-1:0] RAM_LO = 24'h001000;
   localparam logic [ADDR_W-1:0] RAM_HI = 24'h004fff;
   localparam logic [ADDR_W-1:0] EEP_LO = 24'h100000;
   localparam logic [ADDR_W-1:0] EEP_HI = 24'h1007ff;
   localparam logic [ADDR_W-1:0] IFR_LO = 24'h1f0000;
   localparam logic [ADDR_W-1:0] IFR_HI = 24'h1f01ff;
   localparam logic [ADDR_W-1:0] PFL_LO = 24'hfe0000;
   localparam logic [ADDR_W-1:0] PFL_HI = 24'hffffff;

   localparam logic [RADDR_W-1:0] OFS_MODE = 16'h0070;
   localparam logic [RADDR_W-1:0] OFS_EC = 16'h0080;
   localparam logic [RADDR_W-1:0] OFS_CCR = 16'h0082;
   localparam logic [RADDR_W-1:0] OFS_PCH = 16'h0085;
   localparam logic [RADDR_W-1:0] OFS_PCM = 16'h0086;
   localparam logic [RADDR_W-1:0] OFS_PCL = 16'h0087;
   localparam logic [RADDR_W-1:0] OFS_IST = 16'h0090;
   localparam logic [RADDR_W-1:0] OFS_IMSK = 16'h0092;

   localparam logic [DATA_W-1:0] EC_CLEAR = 16'hffff;
   localparam int MODE_BIT = 7;
   localparam int CCR_U_BIT = 15;
   localparam int CCR_X_BIT = 6;
   localparam int CCR_I_BIT = 4;
   localparam int ST_U = 2;
   localparam int ST_X = 1;
   localparam int ST_I = 0;
   localparam int IST_ILL = 0;
   localparam int IST_ECC = 1;

   function automatic mmac_code_t tgt_of(input logic [ADDR_W-1:0] a);
      if (a <= REG_HI) return TGT_REG;
      if (a >= RAM_LO && a <= RAM_HI) return TGT_RAM;
      if (a >= EEP_LO && a <= EEP_HI) return TGT_EEP;
      if (a >= IFR_LO && a <= IFR_HI) return TGT_IFR;
      if (a >= PFL_LO) return TGT_PFL;
      return TGT_NONE;
   endfunction

   function automatic mmac_res_t res_of(input mmac_code_t t);
      if (t == TGT_RAM) return RES_RAM;
      if (t == TGT_REG) return RES_PER;
      return RES_NVM;
   endfunction

   function automatic logic is_illegal(input mmac_code_t t, input mmac_code_t acc);
      if (t == TGT_NONE) return 1'b1;
      if (acc == ACC_NONE || acc > ACC_STORE) return 1'b1;
      if (acc == ACC_STORE && (t == TGT_EEP || t == TGT_PFL || t == TGT_IFR)) return 1'b1;
      if ((acc == ACC_OPC || acc == ACC_VEC) && t == TGT_REG) return 1'b1;
      return 1'b0;
   endfunction
endpackage

// *** design/mmac_sync3.sv ***
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module mmac_sync3 (
   input wire logic clk,
   input wire logic pin,
   output var logic level
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   // No reset: the chain must keep sampling while reset is held so the level is valid at release.
   always_ff @(posedge clk) begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
         level <= s3_reg;
      end
   end
endmodule
`default_nettype wire

// *** design/mmac_arb.sv ***
// Fixed-priority one-hot grant for one target resource.
`timescale 1ns/1ps
`default_nettype none
module mmac_arb
   import mmac_pkg::*;
(
   input wire logic [mmac_pkg::NINIT-1:0] req,
   output logic [mmac_pkg::NINIT-1:0] gnt
);
   always_comb begin
      gnt = '0;
      for (int i = NINIT - 1; i >= 0; i--) begin
         if (req[i]) begin
            gnt = '0;
            gnt[i] = 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// *** design/mmac_top.sv ***
// Memory map access control hub: decode, arbitration, protection, violation log and mode bit.
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// R01: Serve CPU, debug port and ADC; ADC gets direct memory access.
// R02: Decode every initiator address into one 16 MByte space.
// R03: Accesses to different resources from different initiators proceed together.
// R04: Arbitrate competing initiators by priority; check protection on every access.
// R05: Unsupported or prohibited accesses, such as stores to NVM, are illegal.
// R06: Illegal accesses and uncorrectable ECC errors are both access violations.
// R07: Any violation raises a machine exception toward the CPU.
// R08: A violation logs CPU state, program counter and error cause; only CPU and ADC violations are logged, not BDC ones.
// R09: Active only in run and wait; no bus activity in stop.
// R10: External reset is active low.
// R11: At reset release the mode pin level is latched into the mode bit.
// R12: Only special single-chip to normal single-chip mode change is accepted.
// R13: Writing all ones to the error code pair clears it; else unchanged.
// R14: Initiator field: 0 none, 1 CPU, 3 ADC, others reserved.
// R15: Target field: 0 none, 1 regs, 2 RAM, 3 EEPROM, 4 flash, 5 info row.
// R16: Access field: 0 none, 1 opcode, 2 vector, 3 load, 4 store.
// R17: Error field: 0 none, 1 illegal address, 2 uncorrectable ECC.
module mmac_top
   import mmac_pkg::*;
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic STOP_MODE,
   input wire logic MODE_CONFIG_PIN,
   output logic CHIP_MODE,
   input wire logic CPU_REQ,
   input wire logic [mmac_pkg::ADDR_W-1:0] CPU_ADDR,
   input wire logic [mmac_pkg::CODE_W-1:0] CPU_ACC,
   input wire logic [mmac_pkg::DATA_W-1:0] CPU_WDATA,
   input wire logic [mmac_pkg::ADDR_W-1:0] CPU_PC,
   input wire logic [mmac_pkg::CPU_STATE_W-1:0] CPU_STATE,
   output logic CPU_GNT,
   output logic CPU_DONE,
   output logic CPU_ERR,
   output logic [mmac_pkg::DATA_W-1:0] CPU_RDATA,
   output logic MACHINE_EXC,
   input wire logic BDC_REQ,
   input wire logic [mmac_pkg::ADDR_W-1:0] BDC_ADDR,
   input wire logic [mmac_pkg::CODE_W-1:0] BDC_ACC,
   input wire logic [mmac_pkg::DATA_W-1:0] BDC_WDATA,
   output logic BDC_GNT,
   output logic BDC_DONE,
   output logic BDC_ERR,
   output logic [mmac_pkg::DATA_W-1:0] BDC_RDATA,
   input wire logic ADC_REQ,
   input wire logic [mmac_pkg::ADDR_W-1:0] ADC_ADDR,
   input wire logic [mmac_pkg::CODE_W-1:0] ADC_ACC,
   input wire logic [mmac_pkg::DATA_W-1:0] ADC_WDATA,
   output logic ADC_GNT,
   output logic ADC_DONE,
   output logic ADC_ERR,
   output logic [mmac_pkg::DATA_W-1:0] ADC_RDATA,
   output logic PER_SEL,
   output logic [mmac_pkg::ADDR_W-1:0] PER_ADDR,
   output logic PER_WE,
   output logic [mmac_pkg::DATA_W-1:0] PER_WDATA,
   input wire logic [mmac_pkg::DATA_W-1:0] PER_RDATA,
   output logic RAM_SEL,
   output logic [mmac_pkg::ADDR_W-1:0] RAM_ADDR,
   output logic RAM_WE,
   output logic [mmac_pkg::DATA_W-1:0] RAM_WDATA,
   input wire logic [mmac_pkg::DATA_W-1:0] RAM_RDATA,
   input wire logic RAM_ECC_ERR,
   output logic NVM_SEL,
   output logic [mmac_pkg::ADDR_W-1:0] NVM_ADDR,
   output logic NVM_WE,
   output logic [mmac_pkg::DATA_W-1:0] NVM_WDATA,
   input wire logic [mmac_pkg::DATA_W-1:0] NVM_RDATA,
   input wire logic NVM_ECC_ERR,
   input wire logic [mmac_pkg::RADDR_W-1:0] REG_ADDR,
   input wire logic [mmac_pkg::DATA_W-1:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [mmac_pkg::DATA_W-1:0] REG_RDATA,
   output logic IRQ
);
   import mmac_pkg::*;

   logic i_req [NINIT];
   logic [ADDR_W-1:0] i_addr [NINIT];
   mmac_code_t i_acc [NINIT];
   logic [DATA_W-1:0] i_wdata [NINIT];
   mmac_code_t tgt [NINIT];
   mmac_res_t res [NINIT];
   logic ill [NINIT];
   logic gnt [NINIT];
   logic [NINIT-1:0] rq [NRES];
   logic [NINIT-1:0] g [NRES];
   logic [DATA_W-1:0] mem_rdata [NRES];
   logic mem_ecc [NRES];
   logic msel_reg [NRES];
   logic [ADDR_W-1:0] maddr_reg [NRES];
   logic mwe_reg [NRES];
   logic [DATA_W-1:0] mwdata_reg [NRES];
   logic s1_vld_reg [NINIT];
   logic s1_ill_reg [NINIT];
   mmac_code_t s1_tgt_reg [NINIT];
   mmac_code_t s1_acc_reg [NINIT];
   mmac_res_t s1_res_reg [NINIT];
   logic [ADDR_W-1:0] s1_pc_reg;
   logic [CPU_STATE_W-1:0] s1_st_reg;
   logic ecc [NINIT];
   logic viol [NINIT];
   logic done_reg [NINIT];
   logic err_reg [NINIT];
   logic [DATA_W-1:0] rdata_reg [NINIT];
   logic exc_reg;
   mmac_code_t itr_reg;
   mmac_code_t ltgt_reg;
   mmac_code_t lacc_reg;
   mmac_code_t lerr_reg;
   logic [ADDR_W-1:0] lpc_reg;
   logic [CPU_STATE_W-1:0] lst_reg;
   logic log_now;
   mmac_code_t itr_next;
   mmac_code_t ltgt_next;
   mmac_code_t lacc_next;
   mmac_code_t lerr_next;
   logic ec_clear;
   logic [IRQ_W-1:0] ist_reg;
   logic [IRQ_W-1:0] imsk_reg;
   logic [IRQ_W-1:0] ist_set;
   logic [IRQ_W-1:0] ist_clr;
   logic mode_reg;
   logic cap_pend_reg;
   logic pin_level;
   logic [DATA_W-1:0] rd_reg;
   logic [DATA_W-1:0] rd_next;

   assign i_req[IX_CPU] = CPU_REQ; // R01
   assign i_req[IX_BDC] = BDC_REQ;
   assign i_req[IX_ADC] = ADC_REQ;
   assign i_addr[IX_CPU] = CPU_ADDR;
   assign i_addr[IX_BDC] = BDC_ADDR;
   assign i_addr[IX_ADC] = ADC_ADDR;
   assign i_acc[IX_CPU] = CPU_ACC;
   assign i_acc[IX_BDC] = BDC_ACC;
   assign i_acc[IX_ADC] = ADC_ACC;
   assign i_wdata[IX_CPU] = CPU_WDATA;
   assign i_wdata[IX_BDC] = BDC_WDATA;
   assign i_wdata[IX_ADC] = ADC_WDATA;
   assign mem_rdata[RES_PER] = PER_RDATA;
   assign mem_rdata[RES_RAM] = RAM_RDATA;
   assign mem_rdata[RES_NVM] = NVM_RDATA;
   assign mem_ecc[RES_PER] = 1'b0;
   assign mem_ecc[RES_RAM] = RAM_ECC_ERR;
   assign mem_ecc[RES_NVM] = NVM_ECC_ERR;

   // Decode, protection check and per-resource request vectors.
   always_comb begin
      for (int i = 0; i < NINIT; i++) begin
         tgt[i] = tgt_of(i_addr[i]); // R02 R15
         res[i] = res_of(tgt[i]);
         ill[i] = is_illegal(tgt[i], i_acc[i]); // R04 R05
      end
      for (int r = 0; r < NRES; r++) begin
         for (int i = 0; i < NINIT; i++) begin
            rq[r][i] = i_req[i] && !STOP_MODE && !ill[i] && res[i] == mmac_res_t'(r); // R03 R09
         end
      end
   end

   for (genvar r = 0; r < NRES; r++) begin : g_arb
      mmac_arb u_arb (
         .req(rq[r]),
         .gnt(g[r])
      ); // R04
   end

   // Illegal requests are taken at once and never reach a memory.
   always_comb begin
      for (int i = 0; i < NINIT; i++) begin
         gnt[i] = i_req[i] && !STOP_MODE && ill[i]; // R09
         for (int r = 0; r < NRES; r++) begin
            gnt[i] = gnt[i] | g[r][i];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin // R10
         for (int r = 0; r < NRES; r++) begin
            msel_reg[r] <= 1'b0;
            maddr_reg[r] <= '0;
            mwe_reg[r] <= 1'b0;
            mwdata_reg[r] <= '0;
         end
      end else begin
         for (int r = 0; r < NRES; r++) begin
            msel_reg[r] <= |g[r]; // R03
            mwe_reg[r] <= 1'b0;
            for (int i = 0; i < NINIT; i++) begin
               if (g[r][i]) begin
                  maddr_reg[r] <= i_addr[i];
                  mwe_reg[r] <= i_acc[i] == ACC_STORE;
                  mwdata_reg[r] <= i_wdata[i];
               end
            end
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         s1_pc_reg <= '0;
         s1_st_reg <= '0;
         for (int i = 0; i < NINIT; i++) begin
            s1_vld_reg[i] <= 1'b0;
            s1_ill_reg[i] <= 1'b0;
            s1_tgt_reg[i] <= TGT_NONE;
            s1_acc_reg[i] <= ACC_NONE;
            s1_res_reg[i] <= RES_PER;
         end
      end else begin
         if (gnt[IX_CPU]) begin
            s1_pc_reg <= CPU_PC;
            s1_st_reg <= CPU_STATE;
         end
         for (int i = 0; i < NINIT; i++) begin
            s1_vld_reg[i] <= gnt[i];
            s1_ill_reg[i] <= ill[i];
            s1_tgt_reg[i] <= tgt[i];
            s1_acc_reg[i] <= i_acc[i];
            s1_res_reg[i] <= res[i];
         end
      end
   end

   always_comb begin
      for (int i = 0; i < NINIT; i++) begin
         ecc[i] = s1_vld_reg[i] && !s1_ill_reg[i] && mem_ecc[s1_res_reg[i]];
         viol[i] = s1_vld_reg[i] && (s1_ill_reg[i] || ecc[i]); // R06
      end
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         exc_reg <= 1'b0;
         for (int i = 0; i < NINIT; i++) begin
            done_reg[i] <= 1'b0;
            err_reg[i] <= 1'b0;
            rdata_reg[i] <= '0;
         end
      end else begin
         exc_reg <= viol[IX_CPU] | viol[IX_BDC] | viol[IX_ADC]; // R07
         for (int i = 0; i < NINIT; i++) begin
            done_reg[i] <= s1_vld_reg[i];
            err_reg[i] <= viol[i];
            if (s1_vld_reg[i] && !s1_ill_reg[i]) begin
               rdata_reg[i] <= mem_rdata[s1_res_reg[i]];
            end
         end
      end
   end

   // The first loggable violation is held until software clears the pair.
   always_comb begin
      log_now = 1'b0;
      itr_next = ITR_NONE;
      ltgt_next = TGT_NONE;
      lacc_next = ACC_NONE;
      lerr_next = ERR_NONE;
      if (viol[IX_ADC]) begin
         log_now = 1'b1;
         itr_next = ITR_ADC; // R14
         ltgt_next = s1_tgt_reg[IX_ADC];
         lacc_next = s1_acc_reg[IX_ADC];
         lerr_next = s1_ill_reg[IX_ADC] ? ERR_ILL : ERR_ECC; // R17
      end
      if (viol[IX_CPU]) begin
         log_now = 1'b1;
         itr_next = ITR_CPU; // R14
         ltgt_next = s1_tgt_reg[IX_CPU];
         lacc_next = s1_acc_reg[IX_CPU]; // R16
         lerr_next = s1_ill_reg[IX_CPU] ? ERR_ILL : ERR_ECC; // R17
      end
   end

   assign ec_clear = REG_WR && REG_ADDR == OFS_EC && REG_WDATA == EC_CLEAR; // R13

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         itr_reg <= ITR_NONE;
         ltgt_reg <= TGT_NONE;
         lacc_reg <= ACC_NONE;
         lerr_reg <= ERR_NONE;
         lpc_reg <= '0;
         lst_reg <= '0;
      end else if (log_now && (itr_reg == ITR_NONE || ec_clear)) begin
         itr_reg <= itr_next; // R08
         ltgt_reg <= ltgt_next;
         lacc_reg <= lacc_next;
         lerr_reg <= lerr_next;
         lpc_reg <= s1_pc_reg; // R08
         lst_reg <= s1_st_reg;
      end else if (ec_clear) begin
         itr_reg <= ITR_NONE; // R13
         ltgt_reg <= TGT_NONE;
         lacc_reg <= ACC_NONE;
         lerr_reg <= ERR_NONE;
      end
   end

   always_comb begin
      ist_set = '0;
      ist_clr = '0;
      for (int i = 0; i < NINIT; i++) begin
         ist_set[IST_ILL] = ist_set[IST_ILL] | (s1_vld_reg[i] && s1_ill_reg[i]);
         ist_set[IST_ECC] = ist_set[IST_ECC] | ecc[i];
      end
      if (REG_WR && REG_ADDR == OFS_IST) begin
         ist_clr = REG_WDATA[IRQ_W-1:0];
      end
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         ist_reg <= '0;
         imsk_reg <= '0;
      end else begin
         ist_reg <= (ist_reg & ~ist_clr) | ist_set;
         if (REG_WR && REG_ADDR == OFS_IMSK) begin
            imsk_reg <= REG_WDATA[IRQ_W-1:0];
         end
      end
   end

   mmac_sync3 u_mode_sync (
      .clk(CLK),
      .pin(MODE_CONFIG_PIN),
      .level(pin_level)
   );

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         mode_reg <= 1'b0;
         cap_pend_reg <= 1'b1;
      end else if (cap_pend_reg) begin
         mode_reg <= pin_level; // R11
         cap_pend_reg <= 1'b0;
      end else if (REG_WR && REG_ADDR == OFS_MODE && !mode_reg && REG_WDATA[MODE_BIT]) begin
         mode_reg <= 1'b1; // R12
      end
   end

   always_comb begin
      rd_next = '0;
      unique case (REG_ADDR)
         OFS_MODE: rd_next[MODE_BIT] = mode_reg;
         OFS_EC: rd_next = {itr_reg, ltgt_reg, lacc_reg, lerr_reg};
         OFS_CCR: begin
            rd_next[CCR_U_BIT] = lst_reg[ST_U];
            rd_next[CCR_X_BIT] = lst_reg[ST_X];
            rd_next[CCR_I_BIT] = lst_reg[ST_I];
         end
         OFS_PCH: rd_next[7:0] = lpc_reg[23:16];
         OFS_PCM: rd_next[7:0] = lpc_reg[15:8];
         OFS_PCL: rd_next[7:0] = lpc_reg[7:0];
         OFS_IST: rd_next[IRQ_W-1:0] = ist_reg;
         OFS_IMSK: rd_next[IRQ_W-1:0] = imsk_reg;
         default: rd_next = '0;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         rd_reg <= '0;
      end else begin
         rd_reg <= REG_RD ? rd_next : '0;
      end
   end

   assign CHIP_MODE = mode_reg;
   assign REG_RDATA = rd_reg;
   assign IRQ = |(ist_reg & imsk_reg);
   assign MACHINE_EXC = exc_reg;
   assign CPU_GNT = gnt[IX_CPU];
   assign BDC_GNT = gnt[IX_BDC];
   assign ADC_GNT = gnt[IX_ADC];
   assign CPU_DONE = done_reg[IX_CPU];
   assign BDC_DONE = done_reg[IX_BDC];
   assign ADC_DONE = done_reg[IX_ADC];
   assign CPU_ERR = err_reg[IX_CPU];
   assign BDC_ERR = err_reg[IX_BDC];
   assign ADC_ERR = err_reg[IX_ADC];
   assign CPU_RDATA = rdata_reg[IX_CPU];
   assign BDC_RDATA = rdata_reg[IX_BDC];
   assign ADC_RDATA = rdata_reg[IX_ADC];
   assign PER_SEL = msel_reg[RES_PER];
   assign PER_ADDR = maddr_reg[RES_PER];
   assign PER_WE = mwe_reg[RES_PER];
   assign PER_WDATA = mwdata_reg[RES_PER];
   assign RAM_SEL = msel_reg[RES_RAM];
   assign RAM_ADDR = maddr_reg[RES_RAM];
   assign RAM_WE = mwe_reg[RES_RAM];
   assign RAM_WDATA = mwdata_reg[RES_RAM];
   assign NVM_SEL = msel_reg[RES_NVM];
   assign NVM_ADDR = maddr_reg[RES_NVM];
   assign NVM_WE = mwe_reg[RES_NVM];
   assign NVM_WDATA = mwdata_reg[RES_NVM];

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   chk_arb_onehot: assert property ($onehot0(g[RES_RAM]) && $onehot0(g[RES_NVM])) // R04
      else $error("more than one initiator granted one resource");
   chk_bdc_priority: assert property (BDC_REQ && CPU_REQ && !STOP_MODE && !ill[IX_BDC] && !ill[IX_CPU] // R04
      && res[IX_BDC] == res[IX_CPU] |-> BDC_GNT && !CPU_GNT)
      else $error("priority order broken on shared resource");
   chk_parallel_go: assert property (CPU_REQ && ADC_REQ && !STOP_MODE && !ill[IX_CPU] && !ill[IX_ADC] // R03
      && res[IX_CPU] != res[IX_ADC] && !BDC_REQ |-> CPU_GNT && ADC_GNT)
      else $error("independent resources not served together");
   chk_stop_quiet: assert property (STOP_MODE |=> !PER_SEL && !RAM_SEL && !NVM_SEL) // R09
      else $error("memory selected in stop mode");
   chk_nvm_store: assert property (CPU_REQ && CPU_GNT && CPU_ACC == ACC_STORE && res[IX_CPU] == RES_NVM // R05
      |-> ##1 !NVM_WE ##1 CPU_DONE && CPU_ERR)
      else $error("store to nonvolatile memory not refused");
   chk_unmapped_err: assert property (ADC_GNT && tgt[IX_ADC] == TGT_NONE |-> ##2 ADC_ERR) // R02
      else $error("unmapped address not flagged");
   chk_ecc_viol: assert property (s1_vld_reg[IX_CPU] && !s1_ill_reg[IX_CPU] && RAM_ECC_ERR // R06
      && s1_res_reg[IX_CPU] == RES_RAM && itr_reg == ITR_NONE |=> lerr_reg == ERR_ECC && CPU_ERR)
      else $error("ECC error not logged as violation");
   chk_exc_raise: assert property (CPU_GNT && ill[IX_CPU] |-> ##2 MACHINE_EXC) // R07
      else $error("machine exception missing after violation");
   chk_log_pc: assert property (viol[IX_CPU] && itr_reg == ITR_NONE |=> itr_reg == ITR_CPU // R08
      && lpc_reg == $past(s1_pc_reg))
      else $error("program counter not logged");
   chk_ec_clear: assert property (ec_clear && !log_now |=> itr_reg == ITR_NONE && lerr_reg == ERR_NONE) // R13
      else $error("error code pair not cleared");
   chk_ec_keep: assert property (REG_WR && REG_ADDR == OFS_EC && REG_WDATA != EC_CLEAR // R13
      && itr_reg != ITR_NONE |=> $stable(itr_reg) && $stable(lerr_reg))
      else $error("error code pair changed by other write");
   chk_mode_oneway: assert property (!cap_pend_reg && !$past(cap_pend_reg) |-> !$fell(mode_reg)) // R12
      else $error("mode left normal single-chip");
   chk_mode_capture: assert property (cap_pend_reg |=> mode_reg == $past(pin_level)) // R11
      else $error("mode pin not latched at reset release");
   chk_irq_level: assert property (ist_set[IST_ILL] && imsk_reg[IST_ILL] && !REG_WR |=> IRQ) // R06
      else $error("interrupt output disagrees with status");

   cov_parallel: cover property (RAM_SEL && NVM_SEL);
   cov_nvm_store: cover property (CPU_DONE && CPU_ERR && lacc_reg == ACC_STORE);
   cov_ecc_log: cover property (lerr_reg == ERR_ECC);
   cov_mode_change: cover property (!cap_pend_reg && $rose(mode_reg));
endmodule
`default_nettype wire

// *** test/mmac_mem_model.sv ***
// Combinational memory and peripheral model that answers in the select cycle.
`timescale 1ns/1ps
`default_nettype none
module mmac_mem_model (
   input wire logic clk,
   input wire logic ecc_inj,
   input wire logic per_sel,
   input wire logic [23:0] per_addr,
   input wire logic ram_sel,
   input wire logic [23:0] ram_addr,
   input wire logic nvm_sel,
   input wire logic [23:0] nvm_addr,
   output logic [15:0] per_rdata,
   output logic [15:0] ram_rdata,
   output logic [15:0] nvm_rdata,
   output logic ram_ecc,
   output logic nvm_ecc
);
   logic [15:0] junk = 16'h0;
   always @(posedge clk) junk <= ~junk + 16'h1;
   // Unselected memories show junk, which stays at zero because ~junk + 1 from zero is zero again.
   assign per_rdata = per_sel ? per_addr[15:0] ^ 16'h5a5a : junk;
   assign ram_rdata = ram_sel ? ram_addr[15:0] ^ 16'h5a5a : junk;
   assign nvm_rdata = nvm_sel ? nvm_addr[15:0] ^ 16'h5a5a : junk;
   assign ram_ecc = ram_sel & ecc_inj;
   assign nvm_ecc = nvm_sel & ecc_inj;
endmodule
`default_nettype wire

// *** test/mmac_top_tb_top.sv ***
// Self-checking bench of the memory map access control hub.
`timescale 1ns/1ps
`default_nettype none
module mmac_top_tb_top;
   logic CLK = 1'b0, NRST = 1'b0, STOP_MODE = 1'b0, MODE_CONFIG_PIN = 1'b0, ecc_inj = 1'b0;
   logic CPU_REQ = 1'b0, BDC_REQ = 1'b0, ADC_REQ = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
   logic [23:0] CPU_ADDR = 24'h0, BDC_ADDR = 24'h0, ADC_ADDR = 24'h0, CPU_PC = 24'habcdef;
   logic [3:0] CPU_ACC = 4'h0, BDC_ACC = 4'h0, ADC_ACC = 4'h0;
   logic [2:0] CPU_STATE = 3'h5;
   logic [15:0] CPU_WDATA = 16'h1234, BDC_WDATA = 16'h5678, ADC_WDATA = 16'h9abc;
   logic [15:0] REG_ADDR = 16'h0, REG_WDATA = 16'h0;
   logic CHIP_MODE, CPU_GNT, CPU_DONE, CPU_ERR, MACHINE_EXC, BDC_GNT, BDC_DONE, BDC_ERR, ADC_GNT;
   logic ADC_DONE, ADC_ERR, PER_SEL, PER_WE, RAM_SEL, RAM_WE, NVM_SEL, NVM_WE, RAM_ECC_ERR, NVM_ECC_ERR, IRQ;
   logic [15:0] CPU_RDATA, BDC_RDATA, ADC_RDATA, PER_WDATA, RAM_WDATA, NVM_WDATA;
   logic [15:0] PER_RDATA, RAM_RDATA, NVM_RDATA, REG_RDATA;
   logic [23:0] PER_ADDR, RAM_ADDR, NVM_ADDR, a;
   logic [3:0] c, t, e;
   int n_fail = 0, n_tests = 0;
   // Each row is address, access type, expected target code and expected error code.
   logic [35:0] rows [13] = '{36'h001010320, 36'h001012420, 36'h100010431, 36'hfe0100140, 36'hfe0102441,
      36'h1f0004451, 36'h200000301, 36'h000100211, 36'h1f0006350, 36'h004ffe021, 36'h000400310,
      36'h100000330, 36'h000402410};
   always #2 CLK = ~CLK;
   mmac_top dut (.CLK, .NRST, .STOP_MODE, .MODE_CONFIG_PIN, .CHIP_MODE, .CPU_REQ, .CPU_ADDR, .CPU_ACC,
      .CPU_WDATA, .CPU_PC, .CPU_STATE, .CPU_GNT, .CPU_DONE, .CPU_ERR, .CPU_RDATA, .MACHINE_EXC, .BDC_REQ,
      .BDC_ADDR, .BDC_ACC, .BDC_WDATA, .BDC_GNT, .BDC_DONE, .BDC_ERR, .BDC_RDATA, .ADC_REQ, .ADC_ADDR,
      .ADC_ACC, .ADC_WDATA, .ADC_GNT, .ADC_DONE, .ADC_ERR, .ADC_RDATA, .PER_SEL, .PER_ADDR, .PER_WE,
      .PER_WDATA, .PER_RDATA, .RAM_SEL, .RAM_ADDR, .RAM_WE, .RAM_WDATA, .RAM_RDATA, .RAM_ECC_ERR, .NVM_SEL,
      .NVM_ADDR, .NVM_WE, .NVM_WDATA, .NVM_RDATA, .NVM_ECC_ERR, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
      .REG_RDATA, .IRQ);
   mmac_mem_model mem (.clk(CLK), .ecc_inj(ecc_inj), .per_sel(PER_SEL), .per_addr(PER_ADDR),
      .ram_sel(RAM_SEL), .ram_addr(RAM_ADDR), .nvm_sel(NVM_SEL), .nvm_addr(NVM_ADDR),
      .per_rdata(PER_RDATA), .ram_rdata(RAM_RDATA), .nvm_rdata(NVM_RDATA), .ram_ecc(RAM_ECC_ERR),
      .nvm_ecc(NVM_ECC_ERR));
   task automatic chk(input logic [15:0] s, input logic [15:0] w);
      n_tests++;
      if (s !== w) begin
         n_fail++;
         $display("BAD %0t seen %h want %h", $time, s, w);
      end
   endtask
   task automatic final_report;
      if (n_fail == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic reg_wr(input logic [15:0] ad, input logic [15:0] d);
      @(posedge CLK);
      REG_WR <= 1'b1;
      REG_ADDR <= ad;
      REG_WDATA <= d;
      @(posedge CLK);
      REG_WR <= 1'b0;
      #1;
   endtask
   task automatic reg_rd(input logic [15:0] ad, input logic [15:0] w);
      @(posedge CLK);
      REG_RD <= 1'b1;
      REG_ADDR <= ad;
      @(posedge CLK);
      REG_RD <= 1'b0;
      #1;
      chk(REG_RDATA, w);
   endtask
   // Holds one CPU request for one cycle and returns in the done cycle.
   task automatic cpu(input logic [23:0] ad, input logic [3:0] k);
      @(posedge CLK);
      CPU_REQ <= 1'b1;
      CPU_ADDR <= ad;
      CPU_ACC <= k;
      @(posedge CLK);
      CPU_REQ <= 1'b0;
      @(posedge CLK);
      #1;
   endtask
   initial begin
      repeat (100000) @(posedge CLK);
      n_fail++;
      final_report;
   end
   initial begin
      repeat (8) @(posedge CLK);
      NRST <= 1'b1;
      @(posedge CLK);
      #1;
      chk(CHIP_MODE, 16'h0);
      reg_wr(16'h0092, 16'h0003);
      foreach (rows[i]) begin
         {a, c, t, e} = rows[i];
         cpu(a, c);
         chk(CPU_DONE, 16'h1);
         chk(CPU_ERR, e != 4'h0);
         chk(MACHINE_EXC, e != 4'h0);
         if (e == 4'h0) chk(CPU_RDATA, a[15:0] ^ 16'h5a5a);
         reg_rd(16'h0080, e == 4'h0 ? 16'h0 : {4'h1, t, c, e});
         reg_rd(16'h0090, {15'h0, e != 4'h0});
         chk(IRQ, e != 4'h0);
         reg_wr(16'h0080, 16'hffff);
         reg_wr(16'h0090, 16'h0003);
      end
      ecc_inj <= 1'b1;
      cpu(24'h001020, 4'h3);
      ecc_inj <= 1'b0;
      chk(CPU_ERR, 16'h1);
      reg_rd(16'h0080, 16'h1232);
      reg_rd(16'h0085, 16'h00ab);
      reg_rd(16'h0087, 16'h00ef);
      reg_rd(16'h0082, 16'h8010);
      reg_wr(16'h0080, 16'h1234);
      reg_rd(16'h0080, 16'h1232);
      reg_wr(16'h0092, 16'h0000);
      chk(IRQ, 16'h0);
      reg_rd(16'h0070, 16'h0000);
      reg_wr(16'h0070, 16'h0080);
      chk(CHIP_MODE, 16'h1);
      reg_wr(16'h0070, 16'h0000);
      reg_rd(16'h0070, 16'h0080);
      @(posedge CLK);
      {BDC_REQ, CPU_REQ, ADC_REQ} <= 3'h7;
      {BDC_ACC, CPU_ACC, ADC_ACC} <= 12'h333;
      {BDC_ADDR, CPU_ADDR, ADC_ADDR} <= {24'h001000, 24'h001002, 24'h100000};
      #1;
      chk({BDC_GNT, CPU_GNT, ADC_GNT}, 16'h5);
      @(posedge CLK);
      {BDC_REQ, ADC_REQ} <= 2'h0;
      #1;
      chk(CPU_GNT, 16'h1);
      @(posedge CLK);
      STOP_MODE <= 1'b1;
      #1;
      chk(CPU_GNT, 16'h0);
      chk({BDC_DONE, ADC_DONE, BDC_ERR, ADC_ERR}, 16'hc);
      chk(BDC_RDATA, 16'h4a5a);
      chk(ADC_RDATA, 16'h5a5a);
      repeat (2) @(posedge CLK);
      #1;
      chk({RAM_SEL, PER_SEL, NVM_SEL}, 16'h0);
      CPU_REQ <= 1'b0;
      STOP_MODE <= 1'b0;
      {ADC_REQ, ADC_ADDR} <= {1'b1, 24'h200000};
      cpu(24'h200000, 4'h3);
      chk(ADC_ERR, 16'h1);
      MODE_CONFIG_PIN <= 1'b1;
      {NRST, ADC_REQ} <= 2'h0;
      repeat (8) @(posedge CLK);
      NRST <= 1'b1;
      @(posedge CLK);
      #1;
      chk(CHIP_MODE, 16'h1);
      reg_rd(16'h0080, 16'h0000);
      final_report;
   end
endmodule
`default_nettype wire
